// *** rtl/cfg_word_pkg.sv ***
// constants for the configuration word store and decoder
package cfg_word_pkg;
    localparam int WORD_W = 14;
    localparam logic [13:0] CFG_ADDR = 14'h2007;
    localparam logic [13:0] ERASED_WORD = 14'h3fff;
    // field positions inside the stored word
    localparam int OSC_LSB = 0;
    localparam int WATCHDOG_POS = 3;
    localparam int POWERUP_POS = 4;
    localparam int CP_LSB = 5;
    localparam int BROWNOUT_POS = 7;
    localparam int EEPROM_PROT_POS = 8;
    localparam int RST_PIN_POS = 9;
    localparam int OSC_HI_POS = 10;
    // technology of the word storage
    typedef enum logic [1:0] {TECH_MASK, TECH_OTP, TECH_EPROM, TECH_FLASH}
        mem_tech_t;
    // programmer commands
    typedef enum logic [1:0] {CMD_NONE, CMD_READ, CMD_WRITE, CMD_ERASE}
        prog_cmd_t;
    // decoded oscillator modes
    typedef enum logic [3:0] {
        OSC_LOW_POWER, OSC_STANDARD, OSC_HIGH_SPEED, OSC_RESCAP,
        OSC_EXT_RESCAP, OSC_EXT_RESCAP_CLKO, OSC_INT_RESCAP,
        OSC_INT_RESCAP_CLKO, OSC_RESERVED
    } osc_mode_t;
    // code protect levels
    typedef enum logic [1:0] {CP_OFF, CP_PART_A, CP_PART_B, CP_ALL}
        cp_level_t;
endpackage : cfg_word_pkg

// *** rtl/cfg_field_decode.sv ***
// combinational decode of a configuration word into mode fields
`timescale 1ns/100ps
`default_nettype none
module cfg_field_decode
    import cfg_word_pkg::*;
#(
    parameter bit WIDE_OSC = 1'b1,
    parameter bit SINGLE_CP = 1'b0
) (
    input wire logic [13:0] word_in,
    output logic [1:0] cp_level_out,
    output logic eeprom_protect_out,
    output logic brownout_en_out,
    output logic powerup_timer_en_out,
    output logic reset_pin_mode_out,
    output logic watchdog_en_out,
    output logic [3:0] osc_mode_out,
    output logic clock_output_en_out
);
    logic [2:0] osc_code;
    logic [1:0] cp_code;

    assign osc_code = {word_in[OSC_HI_POS], word_in[OSC_LSB+1],
                       word_in[OSC_LSB]};
    assign cp_code = word_in[CP_LSB+1:CP_LSB];

    // code protect; a one-bit part only looks at the low bit
    always_comb begin
        if (SINGLE_CP) begin
            cp_level_out = cp_code[0] ? CP_OFF : CP_ALL;
        end else begin
            case (cp_code)
                2'h3: cp_level_out = CP_OFF;
                2'h2: cp_level_out = CP_PART_A;
                2'h1: cp_level_out = CP_PART_B;
                default: cp_level_out = CP_ALL;
            endcase
        end
    end

    assign eeprom_protect_out = ~word_in[EEPROM_PROT_POS];
    assign brownout_en_out = word_in[BROWNOUT_POS];
    // brown-out forces the delay timer on whatever its own bit says
    assign powerup_timer_en_out = ~word_in[POWERUP_POS]
                                  | word_in[BROWNOUT_POS];
    assign reset_pin_mode_out = word_in[RST_PIN_POS];
    assign watchdog_en_out = word_in[WATCHDOG_POS];

    // oscillator mode, two or three bit field
    always_comb begin
        clock_output_en_out = 1'b0;
        if (!WIDE_OSC) begin
            case (osc_code[1:0])
                2'h3: osc_mode_out = OSC_RESCAP;
                2'h2: osc_mode_out = OSC_HIGH_SPEED;
                2'h1: osc_mode_out = OSC_STANDARD;
                default: osc_mode_out = OSC_LOW_POWER;
            endcase
        end else begin
            case (osc_code)
                3'h7: begin
                    osc_mode_out = OSC_EXT_RESCAP_CLKO;
                    clock_output_en_out = 1'b1;
                end
                3'h6: osc_mode_out = OSC_EXT_RESCAP;
                3'h5: begin
                    osc_mode_out = OSC_INT_RESCAP_CLKO;
                    clock_output_en_out = 1'b1;
                end
                3'h4: osc_mode_out = OSC_INT_RESCAP;
                3'h3: osc_mode_out = OSC_RESERVED;
                3'h2: osc_mode_out = OSC_HIGH_SPEED;
                3'h1: osc_mode_out = OSC_STANDARD;
                default: osc_mode_out = OSC_LOW_POWER;
            endcase
        end
    end
endmodule : cfg_field_decode
`default_nettype wire

// *** rtl/config_word_decoder.sv ***
// configuration word store, programmer access and power-up latching
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module config_word_decoder
    import cfg_word_pkg::*;
#(
    parameter mem_tech_t MEM_TECH = TECH_FLASH,
    parameter logic [13:0] FACTORY_WORD = 14'h3fff,
    parameter logic [13:0] IMPL_MASK = 14'h07ff,
    parameter bit WIDE_OSC = 1'b1,
    parameter bit SINGLE_CP = 1'b0
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic por_in,
    input wire logic prog_mode_in,
    input wire logic [1:0] prog_cmd_in,
    input wire logic [13:0] prog_addr_in,
    input wire logic [13:0] prog_wdata_in,
    input wire logic uv_erase_in,
    input wire logic ext_reset_pin_in,
    output logic [13:0] prog_rdata_out,
    output logic prog_ack_out,
    output logic prog_array_erase_out,
    output logic [1:0] cp_level_out,
    output logic eeprom_protect_out,
    output logic brownout_en_out,
    output logic powerup_timer_en_out,
    output logic reset_pin_mode_out,
    output logic ext_reset_active_out,
    output logic watchdog_en_out,
    output logic [3:0] osc_mode_out,
    output logic clock_output_en_out,
    output logic cfg_valid_out
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; the first stage feeds only the second
    logic [2:0] prog_sync_reg;
    logic [2:0] uv_sync_reg;
    logic [2:0] rst_sync_reg;
    logic prog_mode_reg;
    logic uv_reg;
    logic rst_pin_reg;

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prog_sync_reg <= 3'h0;
            uv_sync_reg <= 3'h0;
            rst_sync_reg <= 3'h7;
        end else begin
            prog_sync_reg <= {prog_sync_reg[1:0], prog_mode_in};
            uv_sync_reg <= {uv_sync_reg[1:0], uv_erase_in};
            rst_sync_reg <= {rst_sync_reg[1:0], ext_reset_pin_in};
        end
    end

    // a level counts once the second and third stages agree
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prog_mode_reg <= 1'b0;
            uv_reg <= 1'b0;
            rst_pin_reg <= 1'b1;
        end else begin
            if (prog_sync_reg[1] == prog_sync_reg[2]) begin
                prog_mode_reg <= prog_sync_reg[2];
            end
            if (uv_sync_reg[1] == uv_sync_reg[2]) begin
                uv_reg <= uv_sync_reg[2];
            end
            if (rst_sync_reg[1] == rst_sync_reg[2]) begin
                rst_pin_reg <= rst_sync_reg[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stored word and programmer access
    logic [13:0] word_reg;
    logic [13:0] word_next;
    logic hit;
    logic uv_prev_reg;
    logic uv_rise;
    logic factory_loaded_reg;

    // address match plus mode gate; normal operation sees nothing
    assign hit = prog_mode_reg && (prog_addr_in == CFG_ADDR);
    assign uv_rise = uv_reg && !uv_prev_reg;

    always_comb begin
        word_next = word_reg;
        if (hit && prog_cmd_in == CMD_WRITE) begin
            case (MEM_TECH)
                TECH_OTP: word_next = word_reg & prog_wdata_in;
                TECH_EPROM: word_next = word_reg & prog_wdata_in;
                TECH_FLASH: word_next = word_reg & prog_wdata_in;
                default: word_next = word_reg;
            endcase
        end else if (hit && prog_cmd_in == CMD_ERASE
                     && MEM_TECH == TECH_FLASH) begin
            word_next = ERASED_WORD;
        end else if (uv_rise && MEM_TECH == TECH_EPROM) begin
            word_next = ERASED_WORD;
        end
        // unimplemented positions never hold a zero
        word_next = word_next | ~IMPL_MASK;
    end

    // reset reloads the erased word into the store; mask parts load at start
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            word_reg <= ERASED_WORD;
            factory_loaded_reg <= 1'b0;
        end else if (!factory_loaded_reg) begin
            factory_loaded_reg <= 1'b1;
            if (MEM_TECH == TECH_MASK) begin
                word_reg <= FACTORY_WORD | ~IMPL_MASK;
            end
        end else begin
            word_reg <= word_next;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            uv_prev_reg <= 1'b0;
        end else begin
            uv_prev_reg <= uv_reg;
        end
    end

    // uv erase wipes the whole program array too
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prog_array_erase_out <= 1'b0;
        end else begin
            prog_array_erase_out <= uv_rise
                                    && MEM_TECH == TECH_EPROM;
        end
    end

    // read data: raw stored bits, programmed shows 0; firmware gets none
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prog_rdata_out <= 14'h0;
            prog_ack_out <= 1'b0;
        end else begin
            prog_ack_out <= hit && prog_cmd_in != CMD_NONE;
            if (hit && prog_cmd_in == CMD_READ) begin
                prog_rdata_out <= word_reg;
            end else if (!prog_mode_reg) begin
                prog_rdata_out <= 14'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power-on capture of decoded fields
    logic [1:0] dec_cp;
    logic dec_eeprom;
    logic dec_brownout;
    logic dec_powerup;
    logic dec_rpin;
    logic dec_watchdog;
    logic [3:0] dec_osc;
    logic dec_clock_out;

    cfg_field_decode #(
        .WIDE_OSC(WIDE_OSC),
        .SINGLE_CP(SINGLE_CP)
    ) u_decode (
        .word_in(word_reg),
        .cp_level_out(dec_cp),
        .eeprom_protect_out(dec_eeprom),
        .brownout_en_out(dec_brownout),
        .powerup_timer_en_out(dec_powerup),
        .reset_pin_mode_out(dec_rpin),
        .watchdog_en_out(dec_watchdog),
        .osc_mode_out(dec_osc),
        .clock_output_en_out(dec_clock_out)
    );

    // safe defaults until the first capture: everything protected
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cp_level_out <= CP_ALL;
            eeprom_protect_out <= 1'b1;
            brownout_en_out <= 1'b0;
            powerup_timer_en_out <= 1'b1;
            reset_pin_mode_out <= 1'b1;
            watchdog_en_out <= 1'b0;
            osc_mode_out <= OSC_LOW_POWER;
            clock_output_en_out <= 1'b0;
            cfg_valid_out <= 1'b0;
        end else if (por_in && factory_loaded_reg) begin
            cp_level_out <= dec_cp;
            eeprom_protect_out <= dec_eeprom;
            brownout_en_out <= dec_brownout;
            powerup_timer_en_out <= dec_powerup;
            reset_pin_mode_out <= dec_rpin;
            watchdog_en_out <= dec_watchdog;
            osc_mode_out <= dec_osc;
            clock_output_en_out <= dec_clock_out;
            cfg_valid_out <= 1'b1;
        end
    end

    // with the pin as I/O the internal reset stays inactive
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ext_reset_active_out <= 1'b0;
        end else begin
            ext_reset_active_out <= reset_pin_mode_out
                                    && !rst_pin_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks: programmer access
    a_no_normal_ack: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        !prog_mode_reg |=> !prog_ack_out)
        else $error("ack outside programming mode");
    a_ack_pulse: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        hit && prog_cmd_in != CMD_NONE |=> prog_ack_out)
        else $error("accepted command without ack");
    a_read_data: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        hit && prog_cmd_in == CMD_READ |=> prog_rdata_out == $past(word_reg))
        else $error("read data wrong");
    a_no_read_normal: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        !prog_mode_reg ##1 !prog_mode_reg |-> prog_rdata_out == 14'h0)
        else $error("firmware sees the word");
    // checks: stored word; apart from reset, an erase is the only way a bit returns to one
    a_clear_only: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        factory_loaded_reg && !uv_rise
        && !(MEM_TECH == TECH_FLASH && hit && prog_cmd_in == CMD_ERASE)
        |=> (word_reg & ~$past(word_reg)) == 14'h0)
        else $error("bit set without erase");
    a_flash_erase: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        MEM_TECH == TECH_FLASH && factory_loaded_reg && hit
        && prog_cmd_in == CMD_ERASE |=> word_reg == ERASED_WORD)
        else $error("erase left programmed bits");
    a_unimpl_ones: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        factory_loaded_reg |-> (word_reg | IMPL_MASK) == 14'h3fff)
        else $error("unimplemented bit low");
    // checks: captured mode outputs
    a_brownout_timer: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        brownout_en_out |-> powerup_timer_en_out)
        else $error("brown-out without power-up timer");
    a_capture_valid: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        por_in && factory_loaded_reg |=> cfg_valid_out)
        else $error("capture not flagged");
    a_watchdog_capture: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        por_in && factory_loaded_reg
        |=> watchdog_en_out == $past(word_reg[WATCHDOG_POS]))
        else $error("watchdog enable not captured");
    a_hold_fields: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        !por_in |=> $stable(osc_mode_out) && $stable(cp_level_out))
        else $error("fields changed without capture");
    a_pin_io: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        !reset_pin_mode_out ##1 !reset_pin_mode_out |-> !ext_reset_active_out)
        else $error("reset while pin is io");
    // covers for the main scenarios
    c_write: cover property (
        @(posedge sys_clk_in) hit && prog_cmd_in == CMD_WRITE);
    c_read: cover property (
        @(posedge sys_clk_in) hit && prog_cmd_in == CMD_READ);
    c_erase: cover property (
        @(posedge sys_clk_in) hit && prog_cmd_in == CMD_ERASE);
    c_capture: cover property (
        @(posedge sys_clk_in) por_in ##1 cfg_valid_out);
    c_pin_reset: cover property (
        @(posedge sys_clk_in) ext_reset_active_out);
endmodule : config_word_decoder
`default_nettype wire

// *** testbench/cfg_programmer_model.sv ***
// behavioural model of the device programmer on the far side
`timescale 1ns/100ps
`default_nettype none
module cfg_programmer_model
    import cfg_word_pkg::*;
(
    input wire logic clk_in,
    input wire logic ack_in,
    input wire logic [13:0] rdata_in,
    output logic mode_out,
    output logic [1:0] cmd_out,
    output logic [13:0] addr_out,
    output logic [13:0] wdata_out
);
    // idle programmer: mode pin low, no command on the lines
    initial begin
        mode_out = 1'b0;
        cmd_out = CMD_NONE;
        addr_out = 14'h0000;
        wdata_out = 14'h0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // mode pin goes through a three-flop sync, so settle five edges
    task automatic set_mode(input logic m);
        @(posedge clk_in);
        mode_out <= m;
        repeat (5) @(posedge clk_in);
    endtask : set_mode

    // one command, taken at the edge after launch, answer one cycle later
    task automatic run_cmd(input prog_cmd_t c, input logic [13:0] a,
                           input logic [13:0] d, output logic ack,
                           output logic [13:0] rd);
        @(posedge clk_in);
        cmd_out <= c;
        addr_out <= a;
        wdata_out <= d;
        @(posedge clk_in);
        cmd_out <= CMD_NONE;
        // released lines show the inverse so stale values never match
        addr_out <= ~a;
        wdata_out <= ~d;
        #1;
        ack = ack_in;
        rd = rdata_in;
    endtask : run_cmd
endmodule : cfg_programmer_model
`default_nettype wire

// *** testbench/config_word_decoder_bench.sv ***
// self-checking bench for the configuration word store and decoder
`timescale 1ns/100ps
`default_nettype none
module config_word_decoder_bench;
    import cfg_word_pkg::*;
    logic sys_clk_in, nrst_in, por_in, uv_erase_in, ext_reset_pin_in;
    logic mode, ack, ack_seen, eep, brown, pup_tmr, rpin, ext_act;
    logic wdog, clko, valid, arr_erase;
    logic [1:0] cmd, cp;
    logic [3:0] osc;
    logic [13:0] addr, wdata, rdata, rd, w;
    int num_errors = 0;
    int n_checks = 0;
    osc_mode_t osc_tbl [8] = '{OSC_LOW_POWER, OSC_STANDARD,
        OSC_HIGH_SPEED, OSC_RESERVED, OSC_INT_RESCAP, OSC_INT_RESCAP_CLKO,
        OSC_EXT_RESCAP, OSC_EXT_RESCAP_CLKO};

    config_word_decoder u_config_word_decoder (
        .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .por_in(por_in),
        .prog_mode_in(mode), .prog_cmd_in(cmd), .prog_addr_in(addr),
        .prog_wdata_in(wdata), .uv_erase_in(uv_erase_in),
        .ext_reset_pin_in(ext_reset_pin_in), .prog_rdata_out(rdata),
        .prog_ack_out(ack), .prog_array_erase_out(arr_erase),
        .cp_level_out(cp), .eeprom_protect_out(eep),
        .brownout_en_out(brown), .powerup_timer_en_out(pup_tmr),
        .reset_pin_mode_out(rpin), .ext_reset_active_out(ext_act),
        .watchdog_en_out(wdog), .osc_mode_out(osc),
        .clock_output_en_out(clko), .cfg_valid_out(valid)
    );

    cfg_programmer_model u_cfg_programmer_model (
        .clk_in(sys_clk_in), .ack_in(ack), .rdata_in(rdata),
        .mode_out(mode), .cmd_out(cmd), .addr_out(addr),
        .wdata_out(wdata)
    );

    // 100 MHz system clock
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (num_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [13:0] seen, input logic [13:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic op(input prog_cmd_t c, input logic [13:0] a,
                      input logic [13:0] d);
        u_cfg_programmer_model.run_cmd(c, a, d, ack_seen, rd);
    endtask : op

    // one power-on capture strobe, then let the registered fields land
    task automatic capture();
        @(posedge sys_clk_in);
        por_in <= 1'b1;
        @(posedge sys_clk_in);
        por_in <= 1'b0;
        @(posedge sys_clk_in);
        #1;
    endtask : capture

    // expected decode worked out from the stored word bit by bit
    task automatic check_fields(input logic [13:0] v);
        check({12'h000, cp}, {12'h000, ~v[6:5]});
        check({13'h0000, eep}, {13'h0000, ~v[8]});
        check({13'h0000, brown}, {13'h0000, v[7]});
        check({13'h0000, pup_tmr}, {13'h0000, ~v[4] | v[7]});
        check({13'h0000, rpin}, {13'h0000, v[9]});
        check({13'h0000, wdog}, {13'h0000, v[3]});
        check({10'h000, osc}, {10'h000, osc_tbl[{v[10], v[1:0]}]});
        check({13'h0000, clko}, {13'h0000, v[10] & v[0]});
        check({13'h0000, valid}, 14'h0001);
    endtask : check_fields

    ////////////////////////////////////////////////////////////////////////
    // hang guard: the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk_in);
        num_errors++;
        complete_run();
    end

    // main sequence
    initial begin
        nrst_in = 1'b0;
        por_in = 1'b0;
        uv_erase_in = 1'b0;
        ext_reset_pin_in = 1'b1;
        repeat (3) @(posedge sys_clk_in);
        #1;
        check({12'h000, cp}, 14'h0003);
        check({13'h0000, valid}, 14'h0000);
        @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        // outside programming mode the word is hidden
        op(CMD_READ, CFG_ADDR, 14'h0000);
        check({13'h0000, ack_seen}, 14'h0000);
        check(rd, 14'h0000);
        u_cfg_programmer_model.set_mode(1'b1);
        op(CMD_READ, 14'h2000, 14'h0000);
        check({13'h0000, ack_seen}, 14'h0000);
        op(CMD_READ, CFG_ADDR, 14'h0000);
        check({13'h0000, ack_seen}, 14'h0001);
        check(rd, ERASED_WORD);
        // writes only clear, unimplemented bits stay high
        op(CMD_WRITE, CFG_ADDR, 14'h0000);
        op(CMD_READ, CFG_ADDR, 14'h0000);
        check(rd, 14'h3800);
        op(CMD_WRITE, CFG_ADDR, 14'h3fff);
        op(CMD_READ, CFG_ADDR, 14'h0000);
        check(rd, 14'h3800);
        op(CMD_ERASE, CFG_ADDR, 14'h0000);
        op(CMD_READ, CFG_ADDR, 14'h0000);
        check(rd, ERASED_WORD);
        // every oscillator and protect code, with the other bits varied
        for (int i = 0; i < 8; i++) begin
            w = {3'h7, i[2], i[0], ~i[1], i[2], i[1:0] ^ 2'h1,
                 i[0] ^ i[2], ~i[0], 1'b1, i[1:0]};
            op(CMD_ERASE, CFG_ADDR, 14'h0000);
            op(CMD_WRITE, CFG_ADDR, w);
            op(CMD_READ, CFG_ADDR, 14'h0000);
            check(rd, w);
            capture();
            check_fields(w);
        end
        // a new word without a capture strobe leaves the modes alone
        op(CMD_WRITE, CFG_ADDR, 14'h0000);
        repeat (3) @(posedge sys_clk_in);
        #1;
        check_fields(w);
        @(posedge sys_clk_in);
        ext_reset_pin_in <= 1'b0;
        repeat (5) @(posedge sys_clk_in);
        #1;
        check({13'h0000, ext_act}, 14'h0001);
        // capture the cleared word: pin turns to I/O, reset goes quiet
        capture();
        check_fields(14'h3800);
        check({13'h0000, ext_act}, 14'h0000);
        // a flash part ignores the erase window pin entirely
        @(posedge sys_clk_in);
        uv_erase_in <= 1'b1;
        repeat (5) @(posedge sys_clk_in);
        #1;
        check({13'h0000, arr_erase}, 14'h0000);
        op(CMD_READ, CFG_ADDR, 14'h0000);
        check(rd, 14'h3800);
        complete_run();
    end
endmodule : config_word_decoder_bench
`default_nettype wire
